/* File: dpc_defines.svh */
// constants for the display parameter control block
`ifndef DPC_DEFINES_SVH
`define DPC_DEFINES_SVH

// ****************************************
// instruction word layout (bit n of the word is index 17-n)
// ****************************************
`define DPC_WORD_W 18
`define DPC_OPC_HI 17
`define DPC_OPC_LO 12
`define DPC_OPC_PARAM2 6'h11
`define DPC_OPC_PARAM3 6'h12
`define DPC_P2_ESC_EN 11
`define DPC_P2_ESC_SEL 10
`define DPC_P2_BLINK_EN 9
`define DPC_P2_BLINK 8
`define DPC_P2_EDGE_EN 7
`define DPC_P2_EDGE 6
`define DPC_P2_ROT_EN 5
`define DPC_P2_ROT 4
`define DPC_P2_PEN_EN 3
`define DPC_P2_PEN 2
`define DPC_P2_OFS_EN 1
`define DPC_P2_OFS 0
`define DPC_P3_INT_EN 7
`define DPC_P3_IE_STOP 6
`define DPC_P3_IE_PEN 5
`define DPC_P3_IE_EDGE 4
`define DPC_P3_IE_PB 3

// ****************************************
// register port map
// ****************************************
`define DPC_ADDR_W 4
`define DPC_REG_STATUS1 4'h0
`define DPC_REG_STATUS3 4'h1
`define DPC_REG_SKIP_EDGE 4'h2
`define DPC_REG_SKIP_PEN 4'h3
`define DPC_REG_FLAG_CLR 4'h4
`define DPC_REG_CONFIG 4'h5
`define DPC_ST1_ROT 0
`define DPC_ST1_BLINK 1
`define DPC_ST1_OFS 2
`define DPC_ST1_ESC 3
`define DPC_ST1_EDGE_EN 4
`define DPC_ST1_PEN_EN 5
`define DPC_FLAG_STOP 0
`define DPC_FLAG_PEN 1
`define DPC_FLAG_EDGE 2
`define DPC_FLAG_PB 3

// ****************************************
// characters, interrupt service and timing
// ****************************************
`define DPC_ESC_CHAR 7'h7D
`define DPC_CR_CHAR 7'h0D
`define DPC_INT_LEVEL 2'h2
`define DPC_TRAP_ADDR 8'h2C
`define DPC_CLK_NS 100
`define DPC_INTENS_NS 250
`define DPC_FETCH_NS 500
`define DPC_SETTLE_US 20
`define DPC_BLINK_MS 125
`define DPC_INTENS_CYC ((`DPC_INTENS_NS + `DPC_CLK_NS - 1) / `DPC_CLK_NS)
`define DPC_FETCH_CYC (`DPC_FETCH_NS / `DPC_CLK_NS)
`define DPC_SETTLE_CYC ((`DPC_SETTLE_US * 1000 + `DPC_CLK_NS - 1) / `DPC_CLK_NS)
`define DPC_BLINK_CYC ((`DPC_BLINK_MS * 1000000) / `DPC_CLK_NS)

`endif

/* File: dpc_pkg.sv */
// types for the display parameter control block
package dpc_pkg;

    typedef enum logic [1:0] {
        PT_IDLE,
        PT_INTENS,
        PT_FETCH
    } point_phase_t;

    typedef struct packed {
        logic esc_sel;
        logic blink;
        logic edge_en;
        logic rotate;
        logic pen_en;
        logic offset;
        logic [3:0] int_en;
        logic [3:0] flags;
        logic halt;
        logic irq;
        logic pen_pend;
        logic [2:0] pen_sync;
        logic pen_level;
        logic string_end;
        logic beam_blank;
        logic skip_draw;
        logic settle_busy;
        logic [7:0] settle_cnt;
        logic [20:0] blink_cnt;
        logic blink_phase;
        logic visible;
        point_phase_t pt_phase;
        logic [2:0] pt_cnt;
        logic intensify;
        logic fetch_req;
        logic [7:0] rdata;
    } dpc_state_t;

endpackage

/* File: display_parameter_control.sv */
// parameter-2/3 decode, flags, blink and edge handling of the display processor
`include "dpc_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module display_parameter_control
    import dpc_pkg::*;
#(
    parameter int BLINK_HALF_CYC = `DPC_BLINK_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // display-file words
    input wire logic instr_valid,
    input wire logic [`DPC_WORD_W-1:0] instr_word,
    // character string stream
    input wire logic char_valid,
    input wire logic [6:0] char_code,
    output logic string_end,
    // vector generator
    input wire logic vec_valid,
    input wire logic vec_start_out,
    input wire logic vec_end_out,
    input wire logic vec_beyond_area,
    output logic beam_blank,
    output logic skip_draw,
    output logic settle_busy,
    // point timing
    input wire logic point_start,
    output logic point_intensify,
    output logic fetch_req,
    // flag sources
    input wire logic light_pen_pin,
    input wire logic stop_event,
    input wire logic pushbutton_event,
    // drawing attributes
    output logic blink_on,
    output logic blink_visible,
    output logic rotate_on,
    output logic offset_on,
    output logic halt,
    // host interrupt request
    output logic int_request,
    output logic [1:0] int_level,
    output logic [7:0] int_trap_addr,
    // register port
    input wire logic [`DPC_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);

    // ****************************************
    // constants
    // ****************************************
    localparam logic [2:0] INTENS_CYC = 3'(`DPC_INTENS_CYC);
    localparam logic [2:0] FETCH_CYC = 3'(`DPC_FETCH_CYC);
    localparam logic [7:0] SETTLE_CYC = 8'(`DPC_SETTLE_CYC);
    localparam logic [20:0] BLINK_HALF = 21'(BLINK_HALF_CYC);

    dpc_state_t cur_ff;
    dpc_state_t nxt_st;
    logic is_p2;
    logic is_p3;
    logic pen_hit;
    logic [3:0] raise;
    logic [3:0] clr_mask;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        nxt_st = cur_ff;
        is_p2 = instr_valid && (instr_word[`DPC_OPC_HI:`DPC_OPC_LO] == `DPC_OPC_PARAM2);
        is_p3 = instr_valid && (instr_word[`DPC_OPC_HI:`DPC_OPC_LO] == `DPC_OPC_PARAM3);
        raise = 4'h0;
        clr_mask = 4'h0;

        // parameter 2 fields
        if (is_p2) begin
            if (instr_word[`DPC_P2_ESC_EN]) begin
                nxt_st.esc_sel = instr_word[`DPC_P2_ESC_SEL];
            end
            if (instr_word[`DPC_P2_BLINK_EN]) begin
                nxt_st.blink = instr_word[`DPC_P2_BLINK];
            end
            if (instr_word[`DPC_P2_EDGE_EN]) begin
                nxt_st.edge_en = instr_word[`DPC_P2_EDGE];
            end
            if (instr_word[`DPC_P2_ROT_EN]) begin
                nxt_st.rotate = instr_word[`DPC_P2_ROT];
            end
            if (instr_word[`DPC_P2_PEN_EN]) begin
                nxt_st.pen_en = instr_word[`DPC_P2_PEN];
            end
            if (instr_word[`DPC_P2_OFS_EN]) begin
                nxt_st.offset = instr_word[`DPC_P2_OFS];
            end
        end

        // parameter 3 interrupt enables
        if (is_p3 && instr_word[`DPC_P3_INT_EN]) begin
            nxt_st.int_en[`DPC_FLAG_STOP] = instr_word[`DPC_P3_IE_STOP];
            nxt_st.int_en[`DPC_FLAG_PEN] = instr_word[`DPC_P3_IE_PEN];
            nxt_st.int_en[`DPC_FLAG_EDGE] = instr_word[`DPC_P3_IE_EDGE];
            nxt_st.int_en[`DPC_FLAG_PB] = instr_word[`DPC_P3_IE_PB];
        end

        // string termination
        nxt_st.string_end = char_valid && ((char_code == `DPC_ESC_CHAR)
            || (cur_ff.esc_sel && (char_code == `DPC_CR_CHAR)));

        // vector edge handling
        if (vec_valid) begin
            nxt_st.beam_blank = vec_start_out || vec_end_out;
            nxt_st.skip_draw = vec_start_out && vec_end_out;
            if (vec_start_out && !vec_end_out) begin
                nxt_st.settle_busy = 1'b1;
                nxt_st.settle_cnt = SETTLE_CYC;
            end
            if (cur_ff.edge_en && vec_beyond_area) begin
                raise[`DPC_FLAG_EDGE] = 1'b1;
            end
        end else if (cur_ff.settle_busy) begin
            nxt_st.settle_cnt = cur_ff.settle_cnt - 8'h01;
            if (cur_ff.settle_cnt == 8'h01) begin
                nxt_st.settle_busy = 1'b0;
            end
        end

        // light pen: synchronise, catch hit, raise flag one cycle later if enabled
        nxt_st.pen_sync = {cur_ff.pen_sync[1:0], light_pen_pin};
        if (cur_ff.pen_sync[2] == cur_ff.pen_sync[1]) begin
            nxt_st.pen_level = cur_ff.pen_sync[2];
        end
        pen_hit = nxt_st.pen_level && !cur_ff.pen_level;
        if (pen_hit) begin
            nxt_st.pen_pend = 1'b1;
        end
        if (cur_ff.pen_pend) begin
            nxt_st.pen_pend = pen_hit;
            raise[`DPC_FLAG_PEN] = cur_ff.pen_en;
        end

        raise[`DPC_FLAG_STOP] = stop_event;
        raise[`DPC_FLAG_PB] = pushbutton_event;

        // point intensify and fetch window
        nxt_st.intensify = 1'b0;
        nxt_st.fetch_req = 1'b0;
        unique case (cur_ff.pt_phase)
            PT_IDLE: begin
                if (point_start) begin
                    nxt_st.pt_phase = PT_INTENS;
                    nxt_st.pt_cnt = INTENS_CYC;
                    nxt_st.intensify = 1'b1;
                end
            end
            PT_INTENS: begin
                nxt_st.pt_cnt = cur_ff.pt_cnt - 3'h1;
                nxt_st.intensify = (cur_ff.pt_cnt != 3'h1);
                if (cur_ff.pt_cnt == 3'h1) begin
                    nxt_st.pt_phase = PT_FETCH;
                    nxt_st.pt_cnt = FETCH_CYC;
                    nxt_st.fetch_req = 1'b1;
                end
            end
            PT_FETCH: begin
                nxt_st.pt_cnt = cur_ff.pt_cnt - 3'h1;
                if (cur_ff.pt_cnt == 3'h1) begin
                    nxt_st.pt_phase = PT_IDLE;
                end
            end
        endcase

        // blink oscillator
        if (cur_ff.blink_cnt == 21'h000000) begin
            nxt_st.blink_cnt = BLINK_HALF - 21'h000001;
            nxt_st.blink_phase = !cur_ff.blink_phase;
        end else begin
            nxt_st.blink_cnt = cur_ff.blink_cnt - 21'h000001;
        end
        nxt_st.visible = !nxt_st.blink || nxt_st.blink_phase;

        // host flag clear, set wins over clear
        if (reg_wr && (reg_addr == `DPC_REG_FLAG_CLR)) begin
            clr_mask = reg_wdata[3:0];
        end
        nxt_st.flags = (cur_ff.flags & ~clr_mask) | raise;
        nxt_st.halt = nxt_st.flags[`DPC_FLAG_STOP] || nxt_st.flags[`DPC_FLAG_PEN]
            || nxt_st.flags[`DPC_FLAG_EDGE];
        nxt_st.irq = |(nxt_st.flags & nxt_st.int_en);

        // register writes steering the block
        if (reg_wr && (reg_addr == `DPC_REG_CONFIG)) begin
            nxt_st.esc_sel = reg_wdata[`DPC_ST1_ESC];
            nxt_st.blink = reg_wdata[`DPC_ST1_BLINK];
            nxt_st.rotate = reg_wdata[`DPC_ST1_ROT];
            nxt_st.offset = reg_wdata[`DPC_ST1_OFS];
            nxt_st.edge_en = reg_wdata[`DPC_ST1_EDGE_EN];
            nxt_st.pen_en = reg_wdata[`DPC_ST1_PEN_EN];
        end

        // register reads
        nxt_st.rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                `DPC_REG_STATUS1, `DPC_REG_CONFIG: begin
                    nxt_st.rdata[`DPC_ST1_ROT] = cur_ff.rotate;
                    nxt_st.rdata[`DPC_ST1_BLINK] = cur_ff.blink;
                    nxt_st.rdata[`DPC_ST1_OFS] = cur_ff.offset;
                    nxt_st.rdata[`DPC_ST1_ESC] = cur_ff.esc_sel;
                    nxt_st.rdata[`DPC_ST1_EDGE_EN] = cur_ff.edge_en;
                    nxt_st.rdata[`DPC_ST1_PEN_EN] = cur_ff.pen_en;
                end
                `DPC_REG_STATUS3: begin
                    nxt_st.rdata = {cur_ff.int_en, cur_ff.flags};
                end
                `DPC_REG_SKIP_EDGE: begin
                    nxt_st.rdata[0] = cur_ff.flags[`DPC_FLAG_EDGE];
                end
                `DPC_REG_SKIP_PEN: begin
                    nxt_st.rdata[0] = cur_ff.flags[`DPC_FLAG_PEN];
                end
                default: begin
                    nxt_st.rdata = 8'h00;
                end
            endcase
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_st;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign string_end = cur_ff.string_end;
    assign beam_blank = cur_ff.beam_blank;
    assign skip_draw = cur_ff.skip_draw;
    assign settle_busy = cur_ff.settle_busy;
    assign point_intensify = cur_ff.intensify;
    assign fetch_req = cur_ff.fetch_req;
    assign blink_on = cur_ff.blink;
    assign blink_visible = cur_ff.visible;
    assign rotate_on = cur_ff.rotate;
    assign offset_on = cur_ff.offset;
    assign halt = cur_ff.halt;
    assign int_request = cur_ff.irq;
    assign int_level = `DPC_INT_LEVEL;
    assign int_trap_addr = `DPC_TRAP_ADDR;
    assign reg_rdata = cur_ff.rdata;

endmodule

`default_nettype wire

/* File: dpc_chk.sv */
// assertion checker for the display parameter control block
`include "dpc_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module dpc_chk #(
    parameter int BLINK_HALF_CYC = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // watched ports
    input wire logic instr_valid,
    input wire logic [`DPC_WORD_W-1:0] instr_word,
    input wire logic char_valid,
    input wire logic [6:0] char_code,
    input wire logic string_end,
    input wire logic vec_valid,
    input wire logic vec_start_out,
    input wire logic vec_end_out,
    input wire logic beam_blank,
    input wire logic settle_busy,
    input wire logic point_start,
    input wire logic point_intensify,
    input wire logic fetch_req,
    input wire logic stop_event,
    input wire logic blink_on,
    input wire logic rotate_on,
    input wire logic offset_on,
    input wire logic halt,
    input wire logic [1:0] int_level,
    input wire logic [7:0] int_trap_addr,
    input wire logic reg_wr
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic p2;
    assign p2 = instr_valid && instr_word[17:12] == 6'h11 && !reg_wr;
    AST_TRAP: assert property (int_level == 2'h2 && int_trap_addr == 8'h2C)
        else $error("interrupt level or trap address wrong");
    AST_STOP_HALT: assert property (stop_event |=> halt)
        else $error("stop flag did not halt");
    AST_BLINK_LD: assert property (p2 && instr_word[9] |=> blink_on == $past(instr_word[8]))
        else $error("blink not loaded");
    AST_BLINK_KEEP: assert property (p2 && !instr_word[9] |=> $stable(blink_on))
        else $error("blink changed without enable");
    AST_ROT_LD: assert property (p2 && instr_word[5] |=> rotate_on == $past(instr_word[4]))
        else $error("rotate not loaded");
    AST_OFS_LD: assert property (p2 && instr_word[1] |=> offset_on == $past(instr_word[0]))
        else $error("offset not loaded");
    AST_POINT: assert property (point_start |=> point_intensify[*3] ##1 (fetch_req && !point_intensify))
        else $error("point timing wrong");
    AST_SETTLE: assert property (vec_valid && vec_start_out && !vec_end_out |=> settle_busy[*8])
        else $error("settle delay missing");
    AST_BLANK: assert property (vec_valid && (vec_start_out || vec_end_out) |=> beam_blank)
        else $error("line outside not blanked");
    AST_ESC_END: assert property (char_valid && char_code == 7'h7D |=> string_end)
        else $error("escape did not end string");
endmodule
bind display_parameter_control dpc_chk #(.BLINK_HALF_CYC(BLINK_HALF_CYC)) u_chk (.*);
`default_nettype wire

/* File: pen_model.sv */
// light pen model answering intensified points after phosphor rise time
`timescale 1ns/1ns
`default_nettype none
module pen_model (
    // control
    input wire logic aim,
    input wire logic point_intensify,
    // pen output
    output logic light_pen_pin
);
    initial light_pen_pin = 1'h0;
    always @(posedge point_intensify) begin
        if (aim) begin
            #1530 light_pen_pin = 1'h1;
            #1000 light_pen_pin = 1'h0;
        end
    end
endmodule
`default_nettype wire

/* File: display_parameter_control_bench.sv */
// self-checking bench for the display parameter control block
`include "dpc_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module display_parameter_control_bench;
    logic clk_sys, rst, instr_valid, char_valid, vec_valid, vec_start_out, vec_end_out;
    logic vec_beyond_area, point_start, stop_event, pushbutton_event, reg_wr, reg_rd, pen_aim;
    logic [`DPC_WORD_W-1:0] instr_word;
    logic [6:0] char_code;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, int_trap_addr;
    logic [1:0] int_level;
    logic light_pen_pin, string_end, beam_blank, skip_draw, settle_busy, point_intensify;
    logic fetch_req, blink_on, blink_visible, rotate_on, offset_on, halt, int_request;
    int checked, miscompares, cyc, n;
    logic prev_vis;
    typedef struct packed {logic [5:0] en; logic [5:0] val; logic [7:0] st1;} row_t;
    row_t rows [6] = '{'{6'h3F, 6'h3F, 8'h3F}, '{6'h00, 6'h00, 8'h3F}, '{6'h10, 6'h00, 8'h3D},
        '{6'h2A, 6'h00, 8'h05}, '{6'h15, 6'h3F, 8'h07}, '{6'h05, 6'h00, 8'h02}};

    display_parameter_control #(.BLINK_HALF_CYC(8)) dut (.*);
    pen_model pen (.aim(pen_aim), .point_intensify(point_intensify), .light_pen_pin(light_pen_pin));

    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc > 5000) begin
            miscompares++;
            finish_test;
        end
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    function automatic logic [17:0] p2w(input logic [5:0] en, input logic [5:0] v);
        p2w = {6'h11, 12'h000};
        for (int i = 0; i < 6; i++) begin
            p2w[2*i+1] = en[i];
            p2w[2*i] = v[i];
        end
    endfunction
    function automatic logic [17:0] p3w(input logic u, input logic [3:0] e);
        p3w = {6'h12, 4'h0, u, e[0], e[1], e[2], e[3], 3'h0};
    endfunction
    task automatic instr(input logic [17:0] w);
        @(posedge clk_sys);
        instr_valid <= 1'h1;
        instr_word <= w;
        @(posedge clk_sys);
        instr_valid <= 1'h0;
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
    endtask
    task automatic rc(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic ch(input logic [6:0] c, input logic e);
        @(posedge clk_sys);
        char_valid <= 1'h1;
        char_code <= c;
        @(posedge clk_sys);
        char_valid <= 1'h0;
        #1 chk({7'h0, string_end}, {7'h0, e});
    endtask
    task automatic vec(input logic s, input logic e, input logic b);
        @(posedge clk_sys);
        {vec_valid, vec_start_out, vec_end_out, vec_beyond_area} <= {1'h1, s, e, b};
        @(posedge clk_sys);
        vec_valid <= 1'h0;
        #1;
    endtask
    task automatic ev(input logic pb);
        @(posedge clk_sys);
        {stop_event, pushbutton_event} <= {!pb, pb};
        @(posedge clk_sys);
        {stop_event, pushbutton_event} <= 2'h0;
        #1;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {clk_sys, instr_valid, char_valid, vec_valid, vec_start_out, vec_end_out} = '0;
        {vec_beyond_area, point_start, stop_event, pushbutton_event, reg_wr, reg_rd} = '0;
        {pen_aim, instr_word, char_code, reg_addr, reg_wdata} = '0;
        rst = 1'h1;
        repeat (16) @(posedge clk_sys);
        rst <= 1'h0;
        rc(4'h0, 8'h00);
        foreach (rows[i]) begin
            instr(p2w(rows[i].en, rows[i].val));
            rc(4'h0, rows[i].st1);
            chk({7'h0, blink_on}, {7'h0, rows[i].st1[1]});
        end
        n = 0;
        prev_vis = blink_visible;
        repeat (40) begin
            @(posedge clk_sys);
            #1 if (blink_visible !== prev_vis) n++;
            prev_vis = blink_visible;
        end
        chk({7'h0, n >= 4}, 8'h01);
        chk({7'h0, n <= 5}, 8'h01);
        instr(p2w(6'h10, 6'h00));
        repeat (3) @(posedge clk_sys);
        #1 chk({7'h0, blink_visible}, 8'h01);
        ch(7'h0D, 1'h0);
        ch(7'h7D, 1'h1);
        instr(p2w(6'h20, 6'h20));
        ch(7'h0D, 1'h1);
        ch(7'h41, 1'h0);
        vec(1'h0, 1'h0, 1'h1);
        rc(4'h2, 8'h00);
        instr(p2w(6'h08, 6'h08));
        vec(1'h0, 1'h0, 1'h1);
        rc(4'h2, 8'h01);
        chk({7'h0, halt}, 8'h01);
        vec(1'h0, 1'h1, 1'h0);
        chk({7'h0, beam_blank}, 8'h01);
        chk({7'h0, skip_draw}, 8'h00);
        vec(1'h1, 1'h1, 1'h0);
        chk({7'h0, skip_draw}, 8'h01);
        vec(1'h0, 1'h0, 1'h0);
        chk({7'h0, beam_blank}, 8'h00);
        vec(1'h1, 1'h0, 1'h0);
        n = 0;
        while (settle_busy === 1'h1 && n < 400) begin
            @(posedge clk_sys);
            #1 n++;
        end
        chk(n[7:0], 8'hC8);
        wr(4'h4, 8'h0F);
        instr(p3w(1'h0, 4'hF));
        rc(4'h1, 8'h00);
        instr(p3w(1'h1, 4'h1));
        rc(4'h1, 8'h10);
        ev(1'h0);
        chk({6'h0, halt, int_request}, 8'h03);
        ev(1'h1);
        rc(4'h1, 8'h19);
        wr(4'h4, 8'h01);
        #1 chk({6'h0, halt, int_request}, 8'h00);
        instr(p3w(1'h1, 4'h8));
        chk({7'h0, int_request}, 8'h01);
        wr(4'h4, 8'h0F);
        instr(p2w(6'h02, 6'h02));
        instr(p3w(1'h1, 4'h2));
        pen_aim = 1'h1;
        @(posedge clk_sys);
        point_start <= 1'h1;
        @(posedge clk_sys);
        point_start <= 1'h0;
        n = 0;
        while (int_request !== 1'h1 && n < 60) begin
            @(posedge clk_sys);
            #1 n++;
        end
        rc(4'h3, 8'h01);
        chk({6'h0, halt, int_request}, 8'h03);
        rc(4'hF, 8'h00);
        @(posedge clk_sys);
        rst <= 1'h1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'h0;
        rc(4'h0, 8'h00);
        rc(4'h1, 8'h00);
        chk({6'h0, halt, int_request}, 8'h00);
        finish_test;
    end
endmodule
`default_nettype wire
